// ### logic/ltc_divider.sv
// Serial restoring divider, one quotient bit per clock
`timescale 1ns/1ns
module ltc_divider #(
   parameter int NW = 21,
   parameter int DW = 13
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic start, // Begin a division
   input wire logic [NW-1:0] num, // Dividend
   input wire logic [DW-1:0] den, // Divisor
   output logic done, // Quotient ready pulse
   output logic [NW-1:0] quo // Quotient
);
   localparam int CW = $clog2(NW + 1);
   logic [DW:0] rem;
   logic [CW-1:0] cnt;
   wire [DW:0] shifted = {rem[DW-1:0], quo[NW-1]};
   // Zero divisor yields all ones, which the caller saturates
   wire fits = shifted >= {1'b0, den};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rem <= '0;
         quo <= '0;
         cnt <= '0;
         done <= 1'b0;
      end else if (start) begin
         rem <= '0;
         quo <= num;
         cnt <= CW'(NW);
         done <= 1'b0;
      end else if (cnt != '0) begin
         rem <= fits ? shifted - {1'b0, den} : shifted;
         quo <= {quo[NW-2:0], fits};
         cnt <= cnt - CW'(1);
         done <= cnt == CW'(1);
      end else begin
         done <= 1'b0;
      end
   end
endmodule : ltc_divider

// ### logic/ltc_path.sv
// Top: register slave, table search and interpolation, trim, clamp, rate pacing
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module ltc_path
   import ltc_pkg::*;
#(
   parameter int TICK_CYCLES = OUT_TICK_CYCLES // Clocks per delivered code
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic [2:0] s_axi_awprot, // Unused protection
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic [2:0] s_axi_arprot, // Unused protection
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic [SAMPLE_W-1:0] comp_sample, // Compensated signed sample
   input wire logic comp_valid, // Sample strobe
   output logic [11:0] out_code, // Limited unsigned code
   output logic out_valid // Code delivery pulse
);
   localparam int TICK_W = $clog2(TICK_CYCLES);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   function automatic logic is_table(input logic [IDX_W-1:0] idx);
      return idx >= IDX_TABLE_WORD_FIRST && idx <= IDX_TABLE_WORD_ODD_LAST;
   endfunction : is_table

   function automatic logic is_known(input logic [IDX_W-1:0] idx);
      return is_table(idx) || idx == IDX_OUTPUT_LIMIT_CODES || idx == IDX_PATH_STATUS
         || idx == IDX_TABLE_LAST_ENTRY_AND_CONTROL || idx == IDX_POST_TABLE_GAIN_OFFSET;
   endfunction : is_known

   function automatic logic [REG24_W-1:0] merge24(input logic [REG24_W-1:0] old,
         input logic [31:0] data, input logic [3:0] strb);
      logic [REG24_W-1:0] r;
      r = old;
      for (int b = 0; b < REG24_W / 8; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge24

   function automatic logic signed [Y_W-1:0] orient(input logic signed [Y_W-1:0] y,
         input logic inv);
      return inv ? -y : y;
   endfunction : orient

   logic [REG24_W-1:0] output_limit_codes;
   logic [CTRL_W-1:0] table_last_entry_and_control;
   logic [REG24_W-1:0] post_table_gain_offset;
   logic aw_held;
   logic w_held;
   logic [IDX_W-1:0] aw_idx;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [IDX_W-1:0] ar_idx;
   logic rd_stage;
   logic [REG24_W-1:0] mem_a_data;
   logic [REG24_W-1:0] mem_b_data;

   ltc_state_e state;
   ltc_state_e next_state;
   logic [TICK_W-1:0] tick_cnt;
   logic [SAMPLE_W-1:0] held_sample;
   logic signed [SAMPLE_W-1:0] v;
   logic [WORD_AW-1:0] scan_k;
   logic [4:0] count;
   logic [X_W-1:0] x_lo;
   logic [X_W-1:0] x_hi;
   logic hi_found;
   logic [X_W-1:0] x_first;
   logic [X_W-1:0] x_second;
   logic [X_W-1:0] x_penult;
   logic signed [Y_W-1:0] table_result;
   logic [11:0] post_trim_result;
   logic [11:0] result_code;
   logic div_done;
   logic [NUM_W-1:0] quo;

   // Bus decode
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire wr_fire = aw_held & w_held;
   wire [IDX_W-1:0] ar_idx_in = s_axi_araddr[ADDR_W-1:2];
   wire [WORD_AW-1:0] rd_word_idx = WORD_AW'(ar_idx_in - IDX_TABLE_WORD_FIRST);
   wire [WORD_AW-1:0] wr_word_idx = WORD_AW'(aw_idx - IDX_TABLE_WORD_FIRST);
   wire mem_we = wr_fire & is_table(aw_idx);
   wire [REG24_W-1:0] rd_word =
      (ar_idx == IDX_OUTPUT_LIMIT_CODES) ? output_limit_codes :
      (ar_idx == IDX_TABLE_LAST_ENTRY_AND_CONTROL) ? REG24_W'(table_last_entry_and_control) :
      (ar_idx == IDX_POST_TABLE_GAIN_OFFSET) ? post_table_gain_offset :
      (ar_idx == IDX_PATH_STATUS) ? {post_trim_result, out_code} :
      is_table(ar_idx) ? mem_b_data : '0;

   // Control fields
   wire table_en = table_last_entry_and_control[TABLE_EN_BIT];
   wire bin_en = table_last_entry_and_control[BIN_EN_BIT];
   wire out_inv = table_last_entry_and_control[OUT_INV_BIT];
   wire in_inv = table_last_entry_and_control[IN_INV_BIT];
   wire [X_W-1:0] x_last = table_last_entry_and_control[X_W-1:0];
   wire [11:0] gain = post_table_gain_offset[GAIN_LSB +: 12];
   wire [11:0] offset = post_table_gain_offset[OFFSET_LSB +: 12];
   wire [11:0] upper_code = output_limit_codes[LIMIT_UPPER_LSB +: 12];
   wire [11:0] lower_limit_value = output_limit_codes[LIMIT_LOWER_LSB +: 12];
   wire [12:0] upper_limit_value = FULL_SCALE - {1'b0, upper_code};

   ltc_table_mem #(.DEPTH(TABLE_WORDS), .WIDTH(REG24_W), .AW(WORD_AW)) u_mem (
      .aclk(aclk),
      .we(mem_we),
      .waddr(wr_word_idx),
      .wdata(w_data[REG24_W-1:0]),
      .wbe(w_strb[REG24_W/8-1:0]),
      .ra_addr(scan_k),
      .ra_data(mem_a_data),
      .rb_addr(rd_word_idx),
      .rb_data(mem_b_data)
   );

   // Write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_idx <= s_axi_awaddr[ADDR_W-1:2];
            s_axi_awready <= 1'b0;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_known(aw_idx) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         output_limit_codes <= '0;
         table_last_entry_and_control <= '0;
         post_table_gain_offset <= '0;
      end else if (wr_fire) begin
         if (aw_idx == IDX_OUTPUT_LIMIT_CODES) begin
            output_limit_codes <= merge24(output_limit_codes, w_data, w_strb);
         end
         if (aw_idx == IDX_TABLE_LAST_ENTRY_AND_CONTROL) begin
            table_last_entry_and_control <= CTRL_W'(merge24(
               REG24_W'(table_last_entry_and_control), w_data, w_strb));
         end
         if (aw_idx == IDX_POST_TABLE_GAIN_OFFSET) begin
            post_table_gain_offset <= merge24(post_table_gain_offset, w_data, w_strb);
         end
      end
   end

   // Read channel: every read waits one extra cycle so table words can pass through the memory
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
         ar_idx <= '0;
         rd_stage <= 1'b0;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         ar_idx <= ar_idx_in;
         rd_stage <= 1'b1;
      end else if (rd_stage) begin
         rd_stage <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {8'h00, rd_word};
         s_axi_rresp <= is_known(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Rate pacing and sample capture
   wire tick = tick_cnt == TICK_LAST;
   wire signed [SAMPLE_W-1:0] sample_neg = (held_sample == SAMPLE_MIN) ? SAMPLE_MAX
      : SAMPLE_W'(-held_sample);
   wire signed [SAMPLE_W-1:0] start_v = (table_en && in_inv) ? sample_neg
      : held_sample;
   wire signed [Y_W-1:0] vx = {v[SAMPLE_W-1], v};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= '0;
         held_sample <= '0;
         out_code <= '0;
         out_valid <= 1'b0;
      end else begin
         tick_cnt <= tick ? '0 : tick_cnt + TICK_W'(1);
         if (comp_valid) begin
            held_sample <= comp_sample;
         end
         out_valid <= tick;
         if (tick) begin
            out_code <= result_code;
         end
      end
   end

   // Threshold search
   wire [X_W-1:0] x_even = mem_a_data[X_EVEN_LSB +: X_W];
   wire [X_W-1:0] x_odd = mem_a_data[X_ODD_LSB +: X_W];
   wire ge_even = ltc_sx(x_even) <= vx;
   wire ge_odd = ltc_sx(x_odd) <= vx;
   wire ge_last = ltc_sx(x_last) <= vx;
   wire [4:0] count_even = {1'b0, scan_k, 1'b1};
   wire [4:0] count_odd = count_even + 5'h01;

   always_comb begin
      case (state)
         ST_IDLE: next_state = tick ? ST_READ : ST_IDLE;
         ST_READ: next_state = ST_CMP;
         ST_CMP: next_state = (scan_k == LAST_WORD) ? ST_LAST : ST_READ;
         ST_LAST: next_state = ST_DIVGO;
         ST_DIVGO: next_state = (table_en && !bin_en) ? ST_DIVW : ST_TRIM;
         ST_DIVW: next_state = div_done ? ST_TRIM : ST_DIVW;
         ST_TRIM: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Position of the highest entry at or below the input picks the segment
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         v <= '0;
         scan_k <= '0;
         count <= '0;
         x_lo <= '0;
         x_hi <= '0;
         hi_found <= 1'b0;
         x_first <= '0;
         x_second <= '0;
         x_penult <= '0;
      end else if (state == ST_IDLE && tick) begin
         v <= start_v;
         scan_k <= '0;
         count <= '0;
         hi_found <= 1'b0;
      end else if (state == ST_CMP) begin
         scan_k <= scan_k + WORD_AW'(1);
         if (ge_odd) begin
            count <= count_odd;
            x_lo <= x_odd;
         end else if (ge_even) begin
            count <= count_even;
            x_lo <= x_even;
         end
         if (!hi_found && !ge_even) begin
            x_hi <= x_even;
            hi_found <= 1'b1;
         end else if (!hi_found && !ge_odd) begin
            x_hi <= x_odd;
            hi_found <= 1'b1;
         end
         if (scan_k == '0) begin
            x_first <= x_even;
            x_second <= x_odd;
         end
         if (scan_k == LAST_WORD) begin
            x_penult <= x_odd;
         end
      end else if (state == ST_LAST) begin
         if (ge_last) begin
            count <= TABLE_POINTS;
            x_lo <= x_last;
         end else if (!hi_found) begin
            x_hi <= x_last;
            hi_found <= 1'b1;
         end
      end
   end

   // Segment arithmetic
   wire below = count == '0;
   wire above = count == TABLE_POINTS;
   wire signed [Y_W-1:0] seg_base = Y_FIRST
      + Y_W'({5'(count - 5'h01), {Y_STEP_SHIFT{1'b0}}});
   wire signed [Y_W-1:0] bin_y = below ? Y_FLOOR : seg_base;
   wire signed [Y_W-1:0] num_diff = below ? ltc_sx(x_first) - vx : vx - ltc_sx(x_lo);
   wire signed [Y_W-1:0] den_diff = below ? ltc_sx(x_second) - ltc_sx(x_first)
      : above ? ltc_sx(x_last) - ltc_sx(x_penult) : ltc_sx(x_hi) - ltc_sx(x_lo);
   wire [NUM_W-1:0] div_num = {num_diff[SAMPLE_W-1:0], {Y_STEP_SHIFT{1'b0}}};
   // Extrapolation stops one step beyond the end points
   wire [8:0] q_clip = (quo > NUM_W'(Y_STEP)) ? Y_STEP : quo[8:0];
   wire signed [Y_W-1:0] interp_y = below ? Y_FIRST - Y_W'(q_clip)
      : seg_base + Y_W'(q_clip);
   wire div_start = state == ST_DIVGO && table_en && !bin_en;

   ltc_divider #(.NW(NUM_W), .DW(SAMPLE_W)) u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(div_start),
      .num(div_num),
      .den(den_diff[SAMPLE_W-1:0]),
      .done(div_done),
      .quo(quo)
   );

   // Trim: product keeps full width, then saturates to 12 bits
   wire signed [Y_W-1:0] gain_factor = GAIN_ONE + Y_W'(signed'(gain));
   wire signed [2*Y_W-1:0] trim_prod = table_result * gain_factor;
   wire signed [2*Y_W-GAIN_FRAC-1:0] trim_scaled = trim_prod[2*Y_W-1:GAIN_FRAC];
   wire signed [2*Y_W-GAIN_FRAC:0] trim_sum = {trim_scaled[2*Y_W-GAIN_FRAC-1], trim_scaled}
      + (2*Y_W-GAIN_FRAC+1)'(signed'(offset));
   wire trim_ovf = trim_sum[2*Y_W-GAIN_FRAC:11] != {(2*Y_W-GAIN_FRAC-10){trim_sum[11]}};
   wire [11:0] trim_sat = !trim_ovf ? trim_sum[11:0]
      : {trim_sum[2*Y_W-GAIN_FRAC], {11{!trim_sum[2*Y_W-GAIN_FRAC]}}};
   wire [11:0] unsigned_val = trim_sat + UNSIGNED_BIAS;
   // A lower limit above the upper one is not guarded; values above upper get upper, all others get lower
   wire [11:0] limited = ({1'b0, unsigned_val} > upper_limit_value) ? upper_limit_value[11:0]
      : (unsigned_val < lower_limit_value) ? lower_limit_value : unsigned_val;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         table_result <= '0;
         post_trim_result <= '0;
         result_code <= '0;
      end else if (state == ST_DIVGO) begin
         if (!table_en) begin
            table_result <= vx;
         end else if (bin_en) begin
            table_result <= orient(bin_y, out_inv);
         end
      end else if (state == ST_DIVW && div_done) begin
         table_result <= orient(interp_y, out_inv);
      end else if (state == ST_TRIM) begin
         post_trim_result <= trim_sat;
         result_code <= limited;
      end
   end
endmodule : ltc_path

// ### logic/ltc_pkg.sv
// Register map, field layout, constants and types of the trim and clamp path
// Overview of operation
// - Binning mode outputs the fixed y of the highest entry not above the input.
// - Binning acts as 12-bit comparators; equal entries jump to the last one's y.
// - Binning: below the lowest entry gives -2304, above the highest gives +2048.
// - The table transfer applies only while the table enable bit is one.
// - The output inversion bit negates the value leaving the table stage.
// - The input inversion bit negates the value entering the table stage.
// - Trim result is table output times one plus gain, plus offset, 12-bit signed.
// - Gain field is bits 11:0, step two to the minus eleven, range -1 to +1.
// - Offset field is bits 23:12, step one LSB, range -2048 to +2047.
// - Signed trim result becomes unsigned by adding 2048 before the limits.
// - Above upper limit gives upper, else below lower gives lower, else unchanged.
// - Upper limit is 4096 minus the code in limit register bits 11:0.
// - Lower limit is the code in limit register bits 23:12.
// - The limited 12-bit code goes to the output stage at a fixed 16 kHz.
// - Interpolation is linear; ends extrapolate first and last segments to -2304 and +2304.
// - The seventeen y points are fixed, -2048 to +2048 in steps of 256.
package ltc_pkg;
   // Register indices; byte address is four times the index
   localparam int IDX_W = 6;
   localparam logic [IDX_W-1:0] IDX_OUTPUT_LIMIT_CODES = 6'h08;
   localparam logic [IDX_W-1:0] IDX_TABLE_WORD_FIRST = 6'h0a;
   localparam logic [IDX_W-1:0] IDX_TABLE_WORD_ODD_LAST = 6'h11;
   localparam logic [IDX_W-1:0] IDX_TABLE_LAST_ENTRY_AND_CONTROL = 6'h12;
   localparam logic [IDX_W-1:0] IDX_POST_TABLE_GAIN_OFFSET = 6'h13;
   localparam logic [IDX_W-1:0] IDX_PATH_STATUS = 6'h14;
   localparam int ADDR_W = IDX_W + 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Widths and field positions
   localparam int REG24_W = 24;
   localparam int CTRL_W = 16;
   localparam int X_W = 12;
   localparam int SAMPLE_W = 13;
   localparam int Y_W = 14;
   localparam int TABLE_WORDS = 8;
   localparam int WORD_AW = 3;
   localparam logic [WORD_AW-1:0] LAST_WORD = 3'h7;
   localparam logic [4:0] TABLE_POINTS = 5'h11;
   localparam int X_EVEN_LSB = 0;
   localparam int X_ODD_LSB = 12;
   localparam int TABLE_EN_BIT = 12;
   localparam int BIN_EN_BIT = 13;
   localparam int OUT_INV_BIT = 14;
   localparam int IN_INV_BIT = 15;
   localparam int GAIN_LSB = 0;
   localparam int OFFSET_LSB = 12;
   localparam int LIMIT_UPPER_LSB = 0;
   localparam int LIMIT_LOWER_LSB = 12;

   // Fixed y points and arithmetic constants
   localparam logic signed [Y_W-1:0] Y_FIRST = 14'sh3800;
   localparam logic signed [Y_W-1:0] Y_FLOOR = 14'sh3700;
   localparam int Y_STEP_SHIFT = 8;
   localparam logic [8:0] Y_STEP = 9'h100;
   localparam logic signed [Y_W-1:0] GAIN_ONE = 14'sh0800;
   localparam int GAIN_FRAC = 11;
   localparam logic [11:0] UNSIGNED_BIAS = 12'h800;
   localparam logic [12:0] FULL_SCALE = 13'h1000;
   localparam logic [SAMPLE_W-1:0] SAMPLE_MIN = 13'h1000;
   localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 13'h0fff;
   localparam int NUM_W = SAMPLE_W + Y_STEP_SHIFT;

   // Output rate
   localparam int CLK_PERIOD_NS = 10;
   localparam int OUT_PERIOD_NS = 62500;
   localparam int OUT_TICK_CYCLES = OUT_PERIOD_NS / CLK_PERIOD_NS;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_READ = 7'h02,
      ST_CMP = 7'h04,
      ST_LAST = 7'h08,
      ST_DIVGO = 7'h10,
      ST_DIVW = 7'h20,
      ST_TRIM = 7'h40
   } ltc_state_e;

   function automatic logic signed [Y_W-1:0] ltc_sx(input logic [X_W-1:0] x);
      return {{(Y_W - X_W){x[X_W-1]}}, x};
   endfunction : ltc_sx
endpackage : ltc_pkg

// ### logic/ltc_table_mem.sv
// Threshold table memory: one byte-enabled write port, two registered read ports
`timescale 1ns/1ns
module ltc_table_mem #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 24,
   parameter int AW = 3
) (
   input wire logic aclk, // Clock
   input wire logic we, // Write strobe
   input wire logic [AW-1:0] waddr, // Write word
   input wire logic [WIDTH-1:0] wdata, // Write data
   input wire logic [WIDTH/8-1:0] wbe, // Byte enables
   input wire logic [AW-1:0] ra_addr, // Search port word
   output logic [WIDTH-1:0] ra_data, // Search port data
   input wire logic [AW-1:0] rb_addr, // Bus port word
   output logic [WIDTH-1:0] rb_data // Bus port data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge aclk) begin
      for (int b = 0; b < WIDTH / 8; b++) begin
         if (we && wbe[b]) begin
            mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
         end
      end
      ra_data <= mem[ra_addr];
      rb_data <= mem[rb_addr];
   end
endmodule : ltc_table_mem

// ### tb/ltc_far.sv
// Far side model: sample source and code sink
`timescale 1ns/1ns
module ltc_far (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset
   input wire logic [12:0] want, // Next sample
   output logic [12:0] comp_sample, // Sample
   output logic comp_valid, // Sample strobe
   input wire logic [11:0] out_code, // Code
   input wire logic out_valid, // Code strobe
   output logic [11:0] got, // Code taken
   output logic fresh // Code just taken
);
   always_ff @(posedge aclk) begin
      comp_valid <= aresetn;
      comp_sample <= want;
      fresh <= out_valid;
      if (out_valid) got <= out_code;
   end
endmodule : ltc_far

// ### tb/ltc_path_tb.sv
// Self-checking bench of the trim and clamp path
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s exp %0h got %0h", n, e, g); end end
module ltc_path_tb import ltc_pkg::*;;
   logic aclk = 0;
   logic aresetn = 0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [12:0] want = '0, comp_sample;
   logic [11:0] out_code, got;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic comp_valid, out_valid, fresh;
   int bad_count = 0;
   int n_compared = 0;
   always #5 aclk = ~aclk;
   ltc_path #(.TICK_CYCLES(64)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comp_sample, .comp_valid,
      .out_code, .out_valid);
   ltc_far far (.aclk, .aresetn, .want, .comp_sample, .comp_valid, .out_code, .out_valid, .got,
      .fresh);
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [1:0] er);
      logic ad;
      logic dd;
      ad = 0;
      dd = 0;
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do begin
         @(posedge aclk);
         ad |= s_axi_awready;
         dd |= s_axi_wready;
         s_axi_awvalid <= !ad;
         s_axi_wvalid <= !dd;
      end while (!(ad && dd));
      s_axi_bready <= 1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      `CHK("bresp", er, s_axi_bresp)
   endtask : wr
   task automatic rd(input logic [5:0] i, input logic [31:0] e, input logic [1:0] er);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      // Late ready makes the slave hold its answer
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1;
      @(posedge aclk);
      s_axi_rready <= 0;
      `CHK("rdata", e, s_axi_rdata)
      `CHK("rresp", er, s_axi_rresp)
   endtask : rd
   // Third code taken is sure to reflect the sample: one tick captures, the next shows
   task automatic run(input logic [12:0] s, input logic [11:0] e);
      want <= s;
      repeat (3) do @(posedge aclk); while (fresh !== 1'b1);
      `CHK("out_code", e, got)
   endtask : run
   task automatic t_table;
      logic [15:0] md [9] = '{16'h3640, 16'h3640, 16'h3640, 16'h3640, 16'h3640, 16'h7640,
         16'hb640, 16'h1640, 16'h2640};
      logic [12:0] sm [9] = '{13'h00fa, 13'h1ce0, 13'h1cdf, 13'h1830, 13'h06a4, 13'h00fa,
         13'h00fa, 13'h0064, 13'h00fa};
      logic [11:0] ex [9] = '{12'h900, 12'h400, 12'h100, 12'h000, 12'hfff, 12'h700, 12'h600,
         12'h880, 12'h8fa};
      logic [31:0] v;
      for (int k = 0; k < 8; k++) begin
         v = {8'h0, 12'(400 * k - 1400), 12'(400 * k - 1600)};
         wr(IDX_TABLE_WORD_FIRST + 6'(k), v, RESP_OKAY);
      end
      wr(IDX_TABLE_WORD_FIRST + 6'h1, 32'h00ce_0ce0, RESP_OKAY);
      for (int c = 0; c < 9; c++) begin
         wr(IDX_TABLE_LAST_ENTRY_AND_CONTROL, {16'h0, md[c]}, RESP_OKAY);
         run(sm[c], ex[c]);
      end
   endtask : t_table
   task automatic t_regs;
      rd(IDX_OUTPUT_LIMIT_CODES, 32'h0, RESP_OKAY);
      wr(IDX_POST_TABLE_GAIN_OFFSET, 32'hff00_a400, RESP_OKAY);
      s_axi_wstrb <= 4'h2;
      wr(IDX_POST_TABLE_GAIN_OFFSET, 32'hffff_a4ff, RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(IDX_POST_TABLE_GAIN_OFFSET, 32'h0000_a400, RESP_OKAY);
      wr(IDX_PATH_STATUS, 32'h0, RESP_OKAY);
      wr(6'h3f, 32'h1, RESP_SLVERR);
      rd(6'h3f, 32'h0, RESP_SLVERR);
   endtask : t_regs
   task automatic t_trim;
      run(13'h00c8, 12'h936);
      run(13'h07d0, 12'hfff);
   endtask : t_trim
   task automatic t_clamp;
      wr(IDX_OUTPUT_LIMIT_CODES, 32'h0040_0100, RESP_OKAY);
      run(13'h07d0, 12'hf00);
      run(13'h1a24, 12'h400);
      run(13'h0000, 12'h80a);
      rd(IDX_PATH_STATUS, 32'h0000_a80a, RESP_OKAY);
      wr(IDX_TABLE_LAST_ENTRY_AND_CONTROL, 32'h1640, RESP_OKAY);
      wr(IDX_POST_TABLE_GAIN_OFFSET, 32'h0000_0c00, RESP_OKAY);
      run(13'h06a4, 12'hc40);
   endtask : t_clamp
   initial begin
      #200000;
      bad_count++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      run(13'h0064, 12'h864);
      t_table();
      t_regs();
      t_trim();
      t_clamp();
      conclude();
   end
endmodule : ltc_path_tb

// ### tb/ltc_props.sv
// Checker of code pacing and register bus answers
`timescale 1ns/1ns
module ltc_props #(parameter int TICK_CYCLES = 64) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset
   input wire logic s_axi_awvalid, // Bus
   input wire logic s_axi_awready, // Bus
   input wire logic s_axi_wvalid, // Bus
   input wire logic s_axi_wready, // Bus
   input wire logic s_axi_bvalid, // Bus
   input wire logic s_axi_arvalid, // Bus
   input wire logic s_axi_arready, // Bus
   input wire logic [31:0] s_axi_rdata, // Bus
   input wire logic s_axi_rvalid, // Bus
   input wire logic s_axi_rready, // Bus
   input wire logic [11:0] out_code, // Code
   input wire logic out_valid // Code strobe
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   int cnt;
   logic seen;
   // First tick after reset is skipped: reset clears the counter together with the tick counter, so at that tick it reads one more than at the later ones
   always_ff @(posedge aclk) begin
      cnt <= (!aresetn || out_valid) ? 0 : cnt + 1;
      seen <= aresetn && (seen || out_valid);
   end
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   tick_gap_a: assert property (seen |-> out_valid == (cnt == TICK_CYCLES - 1))
      else $error("tick gap");
   code_pulse_a: assert property (out_valid |=> !out_valid)
      else $error("code strobe long");
   code_hold_a: assert property (!out_valid && $past(aresetn) |-> $stable(out_code))
      else $error("code moved");
   write_answer_a: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer");
   read_answer_a: assert property (rd_take |=> !s_axi_rvalid ##1 s_axi_rvalid)
      else $error("read answer");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken early");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken early");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data lost");
endmodule : ltc_props
bind ltc_path ltc_props #(.TICK_CYCLES(TICK_CYCLES)) props (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .out_code, .out_valid);
